//--- rtl/bcrs_top.sv
/*
  Burst count readout sequencer top: selecting counter control, selecting
  counter, count switch and AXI4-Lite register slave.
  Assumes burst counts and disconnect arrive from other clock domains or pins.
*/
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module bcrs_top
  import bcrs_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int STEP_CYCLES = BCRS_STEP_CYCLES,
  parameter int PHASE_OFFSET = BCRS_PHASE_OFFSET
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  // Burst counters and computer pins
  input wire logic [COUNT_W-1:0] COUNT_GROUND,
  input wire logic [COUNT_W-1:0] COUNT_TEXT,
  input wire logic [COUNT_W-1:0] COUNT_AIR,
  input wire logic SELECT_READ,
  input wire logic DISCONNECT,
  output logic BREAK_REQUEST,
  output logic XFER_STROBE,
  output logic [COUNT_W-1:0] XFER_DATA,
  output logic [2:0] SEL_CODE,
  output logic SEL_SPARE,
  // AXI4-Lite
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sr_sync_reg;
  logic [1:0] dc_sync_reg;
  logic sr_prev_reg;
  logic dc_prev_reg;
  logic [COUNT_W-1:0] cg_s1_reg, cg_s2_reg, cg_s3_reg;
  logic [COUNT_W-1:0] ct_s1_reg, ct_s2_reg, ct_s3_reg;
  logic [COUNT_W-1:0] ca_s1_reg, ca_s2_reg, ca_s3_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sr_sync_reg <= 2'h0;
      dc_sync_reg <= 2'h0;
      sr_prev_reg <= 1'b0;
      dc_prev_reg <= 1'b0;
      cg_s1_reg <= '0;
      cg_s2_reg <= '0;
      ct_s1_reg <= '0;
      ct_s2_reg <= '0;
      ca_s1_reg <= '0;
      ca_s2_reg <= '0;
      cg_s3_reg <= '0;
      ct_s3_reg <= '0;
      ca_s3_reg <= '0;
    end else begin
      sr_sync_reg <= {sr_sync_reg[0], SELECT_READ};
      dc_sync_reg <= {dc_sync_reg[0], DISCONNECT};
      sr_prev_reg <= sr_sync_reg[1];
      dc_prev_reg <= dc_sync_reg[1];
      cg_s1_reg <= COUNT_GROUND;
      cg_s2_reg <= cg_s1_reg;
      ct_s1_reg <= COUNT_TEXT;
      ct_s2_reg <= ct_s1_reg;
      ca_s1_reg <= COUNT_AIR;
      ca_s2_reg <= ca_s1_reg;
      cg_s3_reg <= cg_s2_reg;
      ct_s3_reg <= ct_s2_reg;
      ca_s3_reg <= ca_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Count capture
  // ----------------------------------------------------------------
  // A synced word is taken only once two samples agree, so a torn word never reaches the switch
  logic [COUNT_W-1:0] cg_hold_reg, cg_hold_next;
  logic [COUNT_W-1:0] ct_hold_reg, ct_hold_next;
  logic [COUNT_W-1:0] ca_hold_reg, ca_hold_next;

  always_comb begin
    cg_hold_next = (cg_s2_reg == cg_s3_reg) ? cg_s2_reg : cg_hold_reg;
    ct_hold_next = (ct_s2_reg == ct_s3_reg) ? ct_s2_reg : ct_hold_reg;
    ca_hold_next = (ca_s2_reg == ca_s3_reg) ? ca_s2_reg : ca_hold_reg;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cg_hold_reg <= '0;
      ct_hold_reg <= '0;
      ca_hold_reg <= '0;
    end else begin
      cg_hold_reg <= cg_hold_next;
      ct_hold_reg <= ct_hold_next;
      ca_hold_reg <= ca_hold_next;
    end
  end

  // Rising edges of the synchronised pins
  logic sr_pin_pulse;
  logic dc_pin_pulse;
  assign sr_pin_pulse = sr_sync_reg[1] & ~sr_prev_reg;
  assign dc_pin_pulse = dc_sync_reg[1] & ~dc_prev_reg;

  // ----------------------------------------------------------------
  // Drum phase pulses
  // ----------------------------------------------------------------
  logic phase_one;
  logic phase_three;

  bcrs_phase_gen #(
    .PERIOD(STEP_CYCLES),
    .OFFSET(PHASE_OFFSET)
  ) u_phase (
    .clk(CLK_SYS),
    .rst(RST),
    .phase_one(phase_one),
    .phase_three(phase_three)
  );

  // ----------------------------------------------------------------
  // Register bus strobes
  // ----------------------------------------------------------------
  logic sw_start;
  logic sw_disc;

  // ----------------------------------------------------------------
  // Selecting counter control and counter
  // ----------------------------------------------------------------
  logic request_latch_reg, request_latch_next;
  logic run_latch_reg, run_latch_next;
  logic [2:0] code_reg, code_next;
  logic brk_reg, brk_next;
  logic strobe_reg, strobe_next;
  logic [COUNT_W-1:0] data_reg, data_next;
  logic [15:0] xfer_cnt_reg, xfer_cnt_next;
  logic [COUNT_W-1:0] merged;
  logic sel_ground, sel_text, sel_air, sel_spare;
  logic start_pulse, disc_pulse, eq_seven, step, clr;

  assign start_pulse = sr_pin_pulse | sw_start;
  assign disc_pulse = dc_pin_pulse | sw_disc;
  assign eq_seven = (code_reg == BCRS_CODE_SEVEN);
  assign step = phase_one & run_latch_reg;
  assign clr = phase_one & ~run_latch_reg;

  always_comb begin
    request_latch_next = request_latch_reg;
    run_latch_next = run_latch_reg;
    code_next = code_reg;
    xfer_cnt_next = xfer_cnt_reg;
    if (disc_pulse | eq_seven) begin
      request_latch_next = 1'b0;
    end
    // A start in the same cycle as a clear wins
    if (start_pulse) begin
      request_latch_next = 1'b1;
    end
    if (phase_three) begin
      run_latch_next = request_latch_reg;
    end
    if (step) begin
      code_next = code_reg + 3'h1;
      xfer_cnt_next = xfer_cnt_reg + 16'h1;
    end
    if (clr | disc_pulse | eq_seven) begin
      code_next = BCRS_CODE_IDLE;
    end
    if (start_pulse & ~request_latch_reg) begin
      xfer_cnt_next = 16'h0;
    end
    brk_next = step;
    strobe_next = step;
    // Current selection latched at the step; idle code gives zeros
    data_next = step ? merged : data_reg;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      request_latch_reg <= 1'b0;
      run_latch_reg <= 1'b0;
      code_reg <= BCRS_CODE_IDLE;
      brk_reg <= 1'b0;
      strobe_reg <= 1'b0;
      data_reg <= '0;
      xfer_cnt_reg <= 16'h0;
    end else begin
      request_latch_reg <= request_latch_next;
      run_latch_reg <= run_latch_next;
      code_reg <= code_next;
      brk_reg <= brk_next;
      strobe_reg <= strobe_next;
      data_reg <= data_next;
      xfer_cnt_reg <= xfer_cnt_next;
    end
  end

  bcrs_count_switch #(
    .W(COUNT_W)
  ) u_switch (
    .code(code_reg),
    .count_ground(cg_hold_reg),
    .count_text(ct_hold_reg),
    .count_air(ca_hold_reg),
    .sel_ground(sel_ground),
    .sel_text(sel_text),
    .sel_air(sel_air),
    .sel_spare(sel_spare),
    .merged(merged)
  );

  assign BREAK_REQUEST = brk_reg;
  assign XFER_STROBE = strobe_reg;
  assign XFER_DATA = data_reg;
  assign SEL_CODE = code_reg;
  assign SEL_SPARE = sel_spare;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_write;
  logic [31:0] status_word;

  assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_full_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign sw_start = do_write & wstrb0_reg & (awaddr_reg == BCRS_OFF_CTRL)
                  & wdata_reg[BCRS_CTRL_START_BIT];
  assign sw_disc = do_write & wstrb0_reg & (awaddr_reg == BCRS_OFF_CTRL)
                 & wdata_reg[BCRS_CTRL_DISC_BIT];
  assign status_word = {22'h0, sel_air, sel_spare, sel_text, sel_ground, code_reg,
                        eq_seven, run_latch_reg, request_latch_reg};

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_AWVALID & S_AXI_AWREADY) begin
      aw_full_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & S_AXI_WREADY) begin
      w_full_next = 1'b1;
      wdata_next = S_AXI_WDATA;
      wstrb0_next = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == BCRS_OFF_CTRL) ? BCRS_RESP_OKAY : BCRS_RESP_DECERR;
    end
    if (bvalid_reg & S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = BCRS_RESP_OKAY;
      case (S_AXI_ARADDR)
        BCRS_OFF_CTRL: begin
          rdata_next = BCRS_RST_WORD;
        end
        BCRS_OFF_STATUS: begin
          rdata_next = status_word;
        end
        BCRS_OFF_DATA: begin
          rdata_next = 32'(data_reg);
        end
        BCRS_OFF_COUNT: begin
          rdata_next = {16'h0, xfer_cnt_reg};
        end
        default: begin
          rdata_next = BCRS_RST_WORD;
          rresp_next = BCRS_RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg & S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= BCRS_RST_WORD;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= BCRS_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= BCRS_RST_WORD;
      rresp_reg <= BCRS_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
endmodule // bcrs_top
`default_nettype wire

//--- inc/bcrs_pkg.sv
/*
  Constants and register map of the burst count readout sequencer.
  Assumes a single 250 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none
// What this block does
// - A select-and-read pulse sets the request latch, starting a read cycle.
// - Request set: next phase-three pulse sets run; phase-one pulses then step.
// - Counter steps once per 10 us, giving a new 3-bit code.
// - Disconnect or equals-seven clears request; next phase-three clears run.
// - With run clear, each phase-one pulse clears the counter instead.
// - Selecting counter is 3-bit modulo eight, starts at zero, counts up.
// - Code all-ones raises equals-seven, which clears counter and ends cycle.
// - Early disconnect clears the counter at once, ending the cycle.
// - Every step pulse goes to the computer as a break-request pulse.
// - Strobe coincident with each step gates selected count to the computer.
// - Code 001 selects ground, 010 slow text, 100 air; 000 selects none.
// - Code 011 gives a decoded output that selects nothing.
// - Each class count bit is ANDed with that class's select line.
// - After five codes all three class counts have been transferred.
// - A strobe with no class selected transfers an all-zero word.
// - Selector outputs merge bit by bit through OR gates.
package bcrs_pkg;
  // Code assignments
  localparam logic [2:0] BCRS_CODE_IDLE = 3'h0;
  localparam logic [2:0] BCRS_CODE_GROUND = 3'h1;
  localparam logic [2:0] BCRS_CODE_TEXT = 3'h2;
  localparam logic [2:0] BCRS_CODE_SPARE = 3'h3;
  localparam logic [2:0] BCRS_CODE_AIR = 3'h4;
  localparam logic [2:0] BCRS_CODE_SEVEN = 3'h7;
  // Timing
  localparam int BCRS_CLK_MHZ = 250;
  localparam int BCRS_STEP_US = 10;
  localparam int BCRS_STEP_CYCLES = BCRS_STEP_US * BCRS_CLK_MHZ;
  localparam int BCRS_PHASE_OFFSET = BCRS_STEP_CYCLES / 2;
  // Register byte offsets
  localparam logic [7:0] BCRS_OFF_CTRL = 8'h00;
  localparam logic [7:0] BCRS_OFF_STATUS = 8'h04;
  localparam logic [7:0] BCRS_OFF_DATA = 8'h08;
  localparam logic [7:0] BCRS_OFF_COUNT = 8'h0c;
  // Control bit positions (write-one pulses)
  localparam int BCRS_CTRL_START_BIT = 0;
  localparam int BCRS_CTRL_DISC_BIT = 1;
  // Reset values and response codes
  localparam logic [31:0] BCRS_RST_WORD = 32'h0;
  localparam logic [1:0] BCRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCRS_RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

//--- rtl/bcrs_phase_gen.sv
/*
  Drum phase pulse generator: phase-one and phase-three pulses, one each per
  step period, half a period apart. Assumes the system clock only.
*/
`timescale 1ns/100ps
`default_nettype none
module bcrs_phase_gen
  import bcrs_pkg::*;
#(
  parameter int PERIOD = BCRS_STEP_CYCLES,
  parameter int OFFSET = BCRS_PHASE_OFFSET
) (
  input wire logic clk,
  input wire logic rst,
  output logic phase_one,
  output logic phase_three
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic one_reg;
  logic one_next;
  logic three_reg;
  logic three_next;

  always_comb begin
    cnt_next = (cnt_reg == 16'(PERIOD - 1)) ? 16'h0 : cnt_reg + 16'h1;
    one_next = (cnt_reg == 16'(PERIOD - 1));
    three_next = (cnt_reg == 16'(OFFSET - 1));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 16'h0;
      one_reg <= 1'b0;
      three_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      one_reg <= one_next;
      three_reg <= three_next;
    end
  end

  assign phase_one = one_reg;
  assign phase_three = three_reg;
endmodule // bcrs_phase_gen
`default_nettype wire

//--- rtl/bcrs_count_switch.sv
/*
  Burst count switch: class decoder, per-class AND selectors and OR merge.
  Purely combinational; code comes from the selecting counter.
*/
`timescale 1ns/100ps
`default_nettype none
module bcrs_count_switch
  import bcrs_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic [2:0] code,
  input wire logic [W-1:0] count_ground,
  input wire logic [W-1:0] count_text,
  input wire logic [W-1:0] count_air,
  output logic sel_ground,
  output logic sel_text,
  output logic sel_air,
  output logic sel_spare,
  output logic [W-1:0] merged
);
  assign sel_ground = (code == BCRS_CODE_GROUND);
  assign sel_text = (code == BCRS_CODE_TEXT);
  assign sel_air = (code == BCRS_CODE_AIR);
  assign sel_spare = (code == BCRS_CODE_SPARE);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // AND per class, OR across classes
      assign merged[i] = (count_ground[i] & sel_ground) | (count_text[i] & sel_text)
                       | (count_air[i] & sel_air);
    end
  endgenerate
endmodule // bcrs_count_switch
`default_nettype wire

//--- tb/bcrs_top_properties.sv
/* Port checker for bcrs_top, bound into it.
   Assumes burst counts stay steady for several cycles around each step. */
`timescale 1ns/100ps
`default_nettype none
module bcrs_top_properties
  import bcrs_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int STEP_CYCLES = 20
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [COUNT_W-1:0] COUNT_GROUND,
  input wire logic [COUNT_W-1:0] COUNT_TEXT,
  input wire logic [COUNT_W-1:0] COUNT_AIR,
  input wire logic DISCONNECT,
  input wire logic BREAK_REQUEST,
  input wire logic XFER_STROBE,
  input wire logic [COUNT_W-1:0] XFER_DATA,
  input wire logic [2:0] SEL_CODE,
  input wire logic SEL_SPARE
);
  int gap_reg;
  int gap_next;
  logic seen_reg;
  logic seen_next;
  // ----------------------------------------
  // Cycles since last step
  // ----------------------------------------
  always_comb begin
    gap_next = BREAK_REQUEST ? 1 : gap_reg + 1;
    seen_next = seen_reg | BREAK_REQUEST;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      gap_reg <= 0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      seen_reg <= seen_next;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_step;
    BREAK_REQUEST;
  endsequence
  sequence s_disc;
    $rose(DISCONNECT);
  endsequence
  a_strobe_pairs: assert property (XFER_STROBE == BREAK_REQUEST)
    else $error("strobe and break request differ");
  a_step_adds_one: assert property (s_step |-> SEL_CODE == 3'($past(SEL_CODE) + 3'h1))
    else $error("step did not add one");
  a_code_moves: assert property ($changed(SEL_CODE) |-> BREAK_REQUEST || SEL_CODE == BCRS_CODE_IDLE)
    else $error("code changed without step or clear");
  a_seven_clears: assert property (SEL_CODE == BCRS_CODE_SEVEN |=> SEL_CODE == BCRS_CODE_IDLE)
    else $error("code seven not cleared");
  a_spare_decode: assert property (SEL_SPARE == (SEL_CODE == BCRS_CODE_SPARE))
    else $error("spare decode wrong");
  a_data_routed: assert property (s_step |-> XFER_DATA == (
    $past(SEL_CODE) == BCRS_CODE_GROUND ? $past(COUNT_GROUND, 3) :
    $past(SEL_CODE) == BCRS_CODE_TEXT ? $past(COUNT_TEXT, 3) :
    $past(SEL_CODE) == BCRS_CODE_AIR ? $past(COUNT_AIR, 3) : '0))
    else $error("transfer word wrong");
  a_step_period: assert property (BREAK_REQUEST && seen_reg |-> gap_reg % STEP_CYCLES == 0)
    else $error("step spacing wrong");
  a_disc_clears: assert property (s_disc |-> ##[1:4] SEL_CODE == BCRS_CODE_IDLE)
    else $error("disconnect did not clear code");
endmodule // bcrs_top_properties
bind bcrs_top bcrs_top_properties #(.COUNT_W(COUNT_W), .STEP_CYCLES(STEP_CYCLES)) i_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .COUNT_GROUND(COUNT_GROUND), .COUNT_TEXT(COUNT_TEXT),
  .COUNT_AIR(COUNT_AIR), .DISCONNECT(DISCONNECT), .BREAK_REQUEST(BREAK_REQUEST),
  .XFER_STROBE(XFER_STROBE), .XFER_DATA(XFER_DATA), .SEL_CODE(SEL_CODE), .SEL_SPARE(SEL_SPARE));
`default_nettype wire

//--- tb/bcrs_computer_model.sv
/* Central computer model: raises select-and-read, counts break requests.
   Assumes want of zero means it never disconnects. */
`timescale 1ns/100ps
`default_nettype none
module bcrs_computer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] want,
  input wire logic break_request,
  output logic select_read,
  output logic disconnect,
  output logic [3:0] seen_count
);
  logic [1:0] sr_reg, sr_next, dc_reg, dc_next;
  logic [3:0] seen_reg, seen_next;
  always_comb begin
    sr_next = go ? 2'h3 : (sr_reg != 2'h0 ? sr_reg - 2'h1 : 2'h0);
    seen_next = go ? 4'h0 : seen_reg + 4'(break_request);
    dc_next = dc_reg != 2'h0 ? dc_reg - 2'h1 : 2'h0;
    if (break_request && want != 4'h0 && seen_reg + 4'h1 == want) begin
      dc_next = 2'h3;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sr_reg <= 2'h0;
      dc_reg <= 2'h0;
      seen_reg <= 4'h0;
    end else begin
      sr_reg <= sr_next;
      dc_reg <= dc_next;
      seen_reg <= seen_next;
    end
  end
  assign select_read = sr_reg != 2'h0;
  assign disconnect = dc_reg != 2'h0;
  assign seen_count = seen_reg;
endmodule // bcrs_computer_model
`default_nettype wire

//--- tb/bcrs_top_tb_top.sv
/* Self-checking bench for bcrs_top with a computer model.
   Assumes short step period parameters. */
`timescale 1ns/100ps
`default_nettype none
module bcrs_top_tb_top;
  import bcrs_pkg::*;
  localparam int W = 16;
  localparam int STEP = 20;
  logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0;
  logic [3:0] want = 4'h0, seen_cnt;
  logic [W-1:0] cnt_g = 16'h1a2b, cnt_t = 16'h3c4d, cnt_a = 16'h5e6f, xdata;
  logic sel_rd, disc, brk, strb, spare, awready, wready, bvalid, arready, rvalid;
  logic [2:0] code;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_word;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp;
  int mismatches = 0, num_checks = 0;
  logic [W-1:0] got [8];

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  bcrs_computer_model i_cpu (.clk(clk_sys), .rst(rst), .go(go), .want(want), .break_request(brk),
    .select_read(sel_rd), .disconnect(disc), .seen_count(seen_cnt));
  bcrs_top #(.COUNT_W(W), .STEP_CYCLES(STEP), .PHASE_OFFSET(STEP / 2)) i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .COUNT_GROUND(cnt_g), .COUNT_TEXT(cnt_t), .COUNT_AIR(cnt_a),
    .SELECT_READ(sel_rd), .DISCONNECT(disc), .BREAK_REQUEST(brk), .XFER_STROBE(strb),
    .XFER_DATA(xdata), .SEL_CODE(code), .SEL_SPARE(spare), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tally_and_finish;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task give_up;
    check(1'b0, "wait ran out");
    tally_and_finish;
  endtask
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) give_up;
    check(bresp === er, "write response");
  endtask
  task axi_read(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_word = rdata;
    rready <= 1'b0;
    if (n == 50) give_up;
    check(rresp === er, "read response");
  endtask
  task collect(input int n);
    int k, t;
    k = 0;
    for (t = 0; t < (n + 2) * STEP && k < n; t++) begin
      @(negedge clk_sys);
      if (brk === 1'b1) begin
        got[k] = xdata;
        check(code === 3'(k + 1), "code after step");
        check(spare === (code === BCRS_CODE_SPARE), "spare decode");
        k++;
      end
    end
    if (k < n) give_up;
  endtask
  task quiet(input int cyc);
    for (int t = 0; t < cyc; t++) begin
      @(negedge clk_sys);
      check(brk === 1'b0, "unexpected step");
    end
  endtask
  task start_cpu(input logic [3:0] w);
    @(posedge clk_sys);
    want <= w;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_full_read;
    start_cpu(4'h5);
    collect(5);
    check(got[0] === '0, "first slot");
    check(got[1] === cnt_g, "ground slot");
    check(got[2] === cnt_t, "text slot");
    check(got[3] === '0, "spare slot");
    check(got[4] === cnt_a, "air slot");
    quiet(3 * STEP);
    check(code === BCRS_CODE_IDLE, "code after disconnect");
  endtask
  task t_to_seven;
    start_cpu(4'h0);
    collect(7);
    check(got[5] === '0 && got[6] === '0, "unassigned slots");
    @(negedge clk_sys);
    check(code === BCRS_CODE_IDLE, "seven not cleared");
    quiet(3 * STEP);
  endtask
  task t_early_disc;
    @(posedge clk_sys);
    cnt_g <= 16'hffff;
    quiet(10);
    start_cpu(4'h2);
    collect(2);
    check(got[1] === 16'hffff, "all-ones ground");
    quiet(3 * STEP);
    check(seen_cnt === 4'h2, "break count");
  endtask
  task t_regs;
    @(posedge clk_sys);
    wstrb <= 4'h0;
    axi_write(BCRS_OFF_CTRL, 32'h1, BCRS_RESP_OKAY);
    wstrb <= 4'hf;
    axi_read(BCRS_OFF_STATUS, BCRS_RESP_OKAY);
    check(rd_word[0] === 1'b0, "start taken without byte strobe");
    axi_write(BCRS_OFF_CTRL, 32'h1, BCRS_RESP_OKAY);
    collect(1);
    axi_write(BCRS_OFF_CTRL, 32'h2, BCRS_RESP_OKAY);
    axi_read(BCRS_OFF_DATA, BCRS_RESP_OKAY);
    check(rd_word === 32'h0, "idle slot data");
    axi_read(BCRS_OFF_STATUS, BCRS_RESP_OKAY);
    check(rd_word[0] === 1'b0, "request after disconnect");
    axi_read(BCRS_OFF_COUNT, BCRS_RESP_OKAY);
    check(rd_word === 32'h1, "step count");
    axi_read(8'h10, BCRS_RESP_DECERR);
    check(rd_word === 32'h0, "unmapped read data");
    axi_write(BCRS_OFF_DATA, 32'h1, BCRS_RESP_DECERR);
    quiet(3 * STEP);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_full_read;
    t_to_seven;
    t_early_disc;
    t_regs;
    tally_and_finish;
  end
endmodule // bcrs_top_tb_top
`default_nettype wire
